// >>> design/pixel_port_pkg.sv
`default_nettype none
package pixel_port_pkg;
  // ************************************************************
  // Frame geometry and formats
  // ************************************************************
  localparam int unsigned LINE_ACTIVE_PIXELS = 320;
  localparam int unsigned FRAME_ACTIVE_LINES = 480;
  localparam logic [8:0] COL_LAST = 9'h13f;
  localparam logic [8:0] ROW_LAST = 9'h1df;
  localparam logic [8:0] POS_ZERO = 9'h000;
  localparam logic [8:0] POS_ONE = 9'h001;
  localparam logic [2:0] FMT_18BPP = 3'h6;
  localparam logic [2:0] FMT_16BPP = 3'h5;
  localparam logic [1:0] FILL_ZERO = 2'h0;
  localparam logic [1:0] FILL_ONE = 2'h1;
  localparam logic [1:0] FILL_REPEAT = 2'h2;
  localparam int unsigned PIX_W = 18;

  // One widened pixel with its raster position
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
    logic [8:0] col;
    logic [8:0] row;
    logic first;
  } pixel_word_t;
endpackage : pixel_port_pkg
`default_nettype wire

// >>> design/pixel_skid_buffer.sv
`default_nettype none
// ************************************************************
// Two-entry buffer with valid and ready on both sides
// ************************************************************
module pixel_skid_buffer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Filling side
  input wire pixel_port_pkg::pixel_word_t wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  // Draining side
  output pixel_port_pkg::pixel_word_t rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  pixel_port_pkg::pixel_word_t mem_r [2];
  pixel_port_pkg::pixel_word_t mem_nxt [2];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Pointer and occupancy update
  always_comb begin
    push = wr_valid_in && (cnt_r != 2'h2);
    pop = (cnt_r != 2'h0) && rd_ready_in;
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wp_r] = wr_data_in;
    end
    wp_nxt = push ? ~wp_r : wp_r;
    rp_nxt = pop ? ~rp_r : rp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  // Registered state
  always_ff @(posedge clk_in) begin
    mem_r <= mem_nxt;
    if (!rst_n_in) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Read data straight from storage registers
  assign rd_data_out = mem_r[rp_r];
  assign rd_valid_out = (cnt_r != 2'h0);
  assign wr_ready_out = (cnt_r != 2'h2);
endmodule : pixel_skid_buffer
`default_nettype wire

// >>> design/rgb_pixel_port_receiver.sv
// What this block does
// - Pixel bus and framing are sampled on the pixel clock rising edge.
// - Frame sync starts each frame; the frame position restarts on it.
// - Line sync starts each line; the column restarts on it.
// - Pixel words are accepted only while pixel_valid is high.
// - One 16 or 18 bit pixel moves per pixel clock period.
// - Line is sync plus back porch plus 320 active plus front porch.
// - Frame is sync plus back porch plus 480 lines plus front porch.
// - Format 3'h6 treats each word as 18-bit colour.
// - Format 3'h5 treats each word as 16-bit colour.
// - 16-bit red and blue widen by fill zero, one, or top-bit repeat.
`default_nettype none
module rgb_pixel_port_receiver (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Pixel port pins
  input wire logic pclk_in,
  input wire logic vsync_in,
  input wire logic hsync_in,
  input wire logic pixel_valid_in,
  input wire logic [17:0] pixel_data_in,
  // Static configuration
  input wire logic [2:0] pixel_format_in,
  input wire logic [1:0] widen_fill_select_in,
  // Pixel stream out
  output logic [17:0] pix_rgb_out,
  output logic [8:0] pix_col_out,
  output logic [8:0] pix_row_out,
  output logic pix_first_out,
  output logic pix_valid_out,
  input wire logic pix_ready_in,
  // Status
  output logic line_error_out,
  output logic frame_error_out,
  output logic overflow_out
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int unsigned SYNC_W = 22;
  logic [SYNC_W-1:0] s1_r, s2_r, s3_r;
  logic [SYNC_W-1:0] s1_nxt;
  logic pclk_rise;

  // First stage only feeds the second
  always_comb begin
    s1_nxt = {pclk_in, vsync_in, hsync_in, pixel_valid_in, pixel_data_in};
  end

  // Sync pipeline; third stage holds the previous clock level
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Pixel clock rising edge; data from the third stage, the set sampled while the clock was still low
  assign pclk_rise = s2_r[21] && !s3_r[21];

  logic vs_now, hs_now, de_now;
  logic [17:0] dat_now;
  assign vs_now = s3_r[20];
  assign hs_now = s3_r[19];
  assign de_now = s3_r[18];
  assign dat_now = s3_r[17:0];

  // ************************************************************
  // Colour widening
  // ************************************************************
  function automatic logic [5:0] widen5(input logic [4:0] f, input logic [1:0] sel);
    logic b;
    b = 1'b0;
    unique case (sel)
      pixel_port_pkg::FILL_ZERO: b = 1'b0;
      pixel_port_pkg::FILL_ONE: b = 1'b1;
      pixel_port_pkg::FILL_REPEAT: b = f[4];
      default: b = 1'b0;
    endcase
    return {f, b};
  endfunction : widen5

  // ************************************************************
  // Framing state
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FRAME = 3'b010,
    ST_HOLD = 3'b100
  } fstate_t;

  fstate_t st_r, st_nxt;
  logic vs_prev_r, vs_prev_nxt, hs_prev_r, hs_prev_nxt;
  logic [8:0] col_r, col_nxt, row_r, row_nxt;
  logic line_seen_r, line_seen_nxt, first_r, first_nxt;
  logic lerr_r, lerr_nxt, ferr_r, ferr_nxt, ovf_r, ovf_nxt;
  logic accept, buf_ready;
  logic [17:0] rgb;
  pixel_port_pkg::pixel_word_t wr_word;

  // Pixel formatting per selected format
  always_comb begin
    rgb = dat_now;
    if (pixel_format_in == pixel_port_pkg::FMT_16BPP) begin
      rgb = {widen5(dat_now[15:11], widen_fill_select_in), dat_now[10:5],
             widen5(dat_now[4:0], widen_fill_select_in)};
    end
  end

  // Position tracking and structure checks
  always_comb begin
    st_nxt = st_r;
    vs_prev_nxt = vs_prev_r;
    hs_prev_nxt = hs_prev_r;
    col_nxt = col_r;
    row_nxt = row_r;
    line_seen_nxt = line_seen_r;
    first_nxt = first_r;
    lerr_nxt = lerr_r;
    ferr_nxt = ferr_r;
    ovf_nxt = ovf_r;
    accept = 1'b0;
    if (pclk_rise) begin
      vs_prev_nxt = vs_now;
      hs_prev_nxt = hs_now;
      unique case (st_r)
        ST_IDLE: begin
          if (vs_now && !vs_prev_r) begin
            st_nxt = ST_FRAME;
            first_nxt = 1'b1;
          end
        end
        ST_FRAME, ST_HOLD: begin
          if (de_now && line_seen_r && (st_r == ST_FRAME)) begin
            accept = (col_r <= pixel_port_pkg::COL_LAST);
            if (accept) begin
              ovf_nxt = ovf_r | ~buf_ready;
              col_nxt = col_r + pixel_port_pkg::POS_ONE;
              first_nxt = 1'b0;
            end
          end
          if (hs_now && !hs_prev_r) begin
            // A line with pixels that did not fill 320 is short
            if (line_seen_r && col_r != pixel_port_pkg::POS_ZERO &&
                col_r != pixel_port_pkg::COL_LAST + pixel_port_pkg::POS_ONE) begin
              lerr_nxt = 1'b1;
            end
            if (col_r != pixel_port_pkg::POS_ZERO) begin
              if (row_r == pixel_port_pkg::ROW_LAST) begin
                st_nxt = ST_HOLD;
              end
              row_nxt = row_r + pixel_port_pkg::POS_ONE;
            end
            col_nxt = pixel_port_pkg::POS_ZERO;
            line_seen_nxt = 1'b1;
          end
          if (vs_now && !vs_prev_r) begin
            if (row_r != pixel_port_pkg::ROW_LAST + pixel_port_pkg::POS_ONE) begin
              ferr_nxt = 1'b1;
            end
            st_nxt = ST_FRAME;
            row_nxt = pixel_port_pkg::POS_ZERO;
            col_nxt = pixel_port_pkg::POS_ZERO;
            line_seen_nxt = 1'b0;
            first_nxt = 1'b1;
          end
        end
      endcase
    end
  end

  // Framing registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= ST_IDLE;
      vs_prev_r <= 1'b0;
      hs_prev_r <= 1'b0;
      col_r <= pixel_port_pkg::POS_ZERO;
      row_r <= pixel_port_pkg::POS_ZERO;
      line_seen_r <= 1'b0;
      first_r <= 1'b0;
      lerr_r <= 1'b0;
      ferr_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      vs_prev_r <= vs_prev_nxt;
      hs_prev_r <= hs_prev_nxt;
      col_r <= col_nxt;
      row_r <= row_nxt;
      line_seen_r <= line_seen_nxt;
      first_r <= first_nxt;
      lerr_r <= lerr_nxt;
      ferr_r <= ferr_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // ************************************************************
  // Output buffer and output registers
  // ************************************************************
  pixel_port_pkg::pixel_word_t rd_word;
  logic rd_valid, take;
  logic out_v_r, out_v_nxt;
  pixel_port_pkg::pixel_word_t out_r, out_nxt;

  // Word offered to the buffer
  always_comb begin
    wr_word.red = rgb[17:12];
    wr_word.green = rgb[11:6];
    wr_word.blue = rgb[5:0];
    wr_word.col = col_r;
    wr_word.row = row_r;
    wr_word.first = first_r;
  end

  pixel_skid_buffer u_buf (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(wr_word),
    .wr_valid_in(accept),
    .wr_ready_out(buf_ready),
    .rd_data_out(rd_word),
    .rd_valid_out(rd_valid),
    .rd_ready_in(take)
  );

  // Output stage loads when empty or being drained
  always_comb begin
    take = !out_v_r || pix_ready_in;
    out_v_nxt = take ? rd_valid : out_v_r;
    out_nxt = (take && rd_valid) ? rd_word : out_r;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      out_v_r <= 1'b0;
      out_r <= '0;
    end else begin
      out_v_r <= out_v_nxt;
      out_r <= out_nxt;
    end
  end

  assign pix_rgb_out = {out_r.red, out_r.green, out_r.blue};
  assign pix_col_out = out_r.col;
  assign pix_row_out = out_r.row;
  assign pix_first_out = out_r.first;
  assign pix_valid_out = out_v_r;
  assign line_error_out = lerr_r;
  assign frame_error_out = ferr_r;
  assign overflow_out = ovf_r;

  // ************************************************************
  // Checks
  // ************************************************************
  a_accept_needs_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    accept |-> pclk_rise) else $error("Pixel taken without clock edge");
  a_accept_needs_valid: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    accept |-> de_now) else $error("Pixel taken without valid");
  a_col_in_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    accept |-> col_r <= 9'h13f) else $error("Column past active area");
  a_vsync_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pclk_rise && vs_now && !vs_prev_r) |=> (row_r == 9'h000 && col_r == 9'h000))
    else $error("Frame position not restarted");
  a_hsync_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pclk_rise && hs_now && !hs_prev_r) |=> col_r == 9'h000) else $error("Column not restarted");
  a_fmt_18bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pixel_format_in == 3'h6) |-> rgb == dat_now) else $error("18-bit word altered");
  a_fill_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pixel_format_in == 3'h5 && widen_fill_select_in == 2'h0) |-> (rgb[12] == 1'b0 && rgb[0] == 1'b0))
    else $error("Zero fill wrong");
  a_fill_repeat: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pixel_format_in == 3'h5 && widen_fill_select_in == 2'h2) |-> (rgb[12] == dat_now[15] && rgb[0] == dat_now[4]))
    else $error("Repeat fill wrong");
  a_one_per_period: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    accept |=> !accept) else $error("Two pixels in one period");
  a_out_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pix_valid_out && !pix_ready_in) |=> ($stable(pix_rgb_out) && pix_valid_out))
    else $error("Output changed under stall");
endmodule : rgb_pixel_port_receiver
`default_nettype wire

// >>> tb/pixel_host_model.sv
`default_nettype none
// ************************************************************
// Host display controller streaming frames
// ************************************************************
module pixel_host_model (
  // Pixel port pins
  output logic pclk_out,
  output logic vsync_out,
  output logic hsync_out,
  output logic pixel_valid_out,
  output logic [17:0] pixel_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pixel clock never stops, 160 ns period
  initial begin
    pclk_out = 1'b0;
    forever #80 pclk_out = ~pclk_out;
  end

  // Idle pins at start
  initial begin
    vsync_out = 1'b0;
    hsync_out = 1'b0;
    pixel_valid_out = 1'b0;
    pixel_data_out = 18'h15555;
  end

  // Clocks without pixels: bus flips so no stale word looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge pclk_out);
      pixel_valid_out = 1'b0;
      pixel_data_out = ~pixel_data_out;
    end
  endtask : idle

  // Two-clock sync pulse, then back porch
  task automatic sync(input bit frame);
    @(negedge pclk_out);
    pixel_valid_out = 1'b0;
    if (frame) begin
      vsync_out = 1'b1;
    end else begin
      hsync_out = 1'b1;
    end
    idle(2);
    vsync_out = 1'b0;
    hsync_out = 1'b0;
    idle(3);
  endtask : sync

  // Run of consecutive pixel words, then front porch
  task automatic line(input int n, input logic [17:0] first_word);
    for (int i = 0; i < n; i++) begin
      @(negedge pclk_out);
      pixel_valid_out = 1'b1;
      pixel_data_out = first_word + 18'(i);
    end
    idle(3);
  endtask : line
endmodule : pixel_host_model
`default_nettype wire

// >>> tb/rgb_pixel_port_receiver_test.sv
`default_nettype none
module rgb_pixel_port_receiver_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] fmt;
    logic [1:0] fill;
    logic [17:0] word;
    logic [17:0] rgb;
  } case_row_t;
  logic clk_in, rst_n_in, pclk, vsync, hsync, pvalid, ready, first, valid, lerr, ferr, ovf;
  logic [17:0] pdata, rgb;
  logic [8:0] col, row;
  logic [2:0] fmt;
  logic [1:0] fill;
  logic [39:0] got [$];
  int n_fail = 0;
  int checked = 0;
  case_row_t rows [5] = '{'{3'h5, 2'h0, 18'h09d46, 18'h26a8c}, '{3'h5, 2'h1, 18'h09d46, 18'h27a8d},
    '{3'h5, 2'h2, 18'h09d46, 18'h27a8c}, '{3'h5, 2'h3, 18'h09d46, 18'h26a8c}, '{3'h6, 2'h0, 18'h2b5e3, 18'h2b5e3}};

  // ************************************************************
  // Clock, parts and output capture
  // ************************************************************
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  pixel_host_model pixel_host_model_inst (.pclk_out(pclk), .vsync_out(vsync), .hsync_out(hsync),
    .pixel_valid_out(pvalid), .pixel_data_out(pdata));

  rgb_pixel_port_receiver rgb_pixel_port_receiver_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .pclk_in(pclk),
    .vsync_in(vsync), .hsync_in(hsync), .pixel_valid_in(pvalid), .pixel_data_in(pdata), .pixel_format_in(fmt),
    .widen_fill_select_in(fill), .pix_rgb_out(rgb), .pix_col_out(col), .pix_row_out(row), .pix_first_out(first),
    .pix_valid_out(valid), .pix_ready_in(ready), .line_error_out(lerr), .frame_error_out(ferr), .overflow_out(ovf));

  // Record each word handed over
  always @(posedge clk_in) begin
    if (rst_n_in && valid === 1'b1 && ready) got.push_back({3'h0, first, rgb, col, row});
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    checked++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset();
    @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    got.delete();
  endtask : do_reset

  // Bounded wait for n captured words
  task automatic wait_for(input int n);
    int k;
    k = 0;
    while (got.size() < n && k < 2000) begin
      @(negedge clk_in);
      k++;
    end
    check(40'(got.size()), 40'(n));
    if (k >= 2000) tally_and_finish();
  endtask : wait_for

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst_n_in = 1'b0;
    ready = 1'b1;
    fmt = pixel_port_pkg::FMT_18BPP;
    fill = pixel_port_pkg::FILL_ZERO;
    repeat (2) @(negedge clk_in);
    check({valid, lerr, ferr, ovf, rgb, col, row}, 40'h0);
    $display("test reset done");
    // Formats and fill modes, one pixel frame each
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_in);
      fmt = rows[i].fmt;
      fill = rows[i].fill;
      do_reset();
      pixel_host_model_inst.sync(1'b1);
      pixel_host_model_inst.sync(1'b0);
      pixel_host_model_inst.line(1, rows[i].word);
      wait_for(1);
      check(got[0], {3'h0, 1'b1, rows[i].rgb, 18'h0});
      $display("test row %0d done", i);
    end
    // Two full lines with two surplus words each
    @(negedge clk_in);
    fmt = pixel_port_pkg::FMT_18BPP;
    do_reset();
    pixel_host_model_inst.sync(1'b1);
    for (int l = 0; l < 2; l++) begin
      pixel_host_model_inst.sync(1'b0);
      pixel_host_model_inst.line(322, 18'h0);
    end
    pixel_host_model_inst.sync(1'b0);
    wait_for(640);
    for (int i = 0; i < 640; i++) begin
      check(got[i], {3'h0, i == 0, 18'(i % 320), 9'(i % 320), 9'(i / 320)});
    end
    check({39'h0, lerr}, 40'h0);
    pixel_host_model_inst.sync(1'b1);
    check({39'h0, ferr}, 40'h1);
    pixel_host_model_inst.sync(1'b0);
    pixel_host_model_inst.line(5, 18'h3);
    pixel_host_model_inst.sync(1'b0);
    check({39'h0, lerr}, 40'h1);
    wait_for(645);
    check(got[640], {3'h0, 1'b1, 18'h3, 18'h0});
    $display("test raster done");
    // Short stall loses nothing, long stall overflows
    do_reset();
    pixel_host_model_inst.sync(1'b1);
    pixel_host_model_inst.sync(1'b0);
    @(negedge clk_in);
    ready = 1'b0;
    pixel_host_model_inst.line(2, 18'h100);
    @(negedge clk_in);
    ready = 1'b1;
    wait_for(2);
    check(got[1], {3'h0, 1'b0, 18'h101, 9'h1, 9'h0});
    check({39'h0, ovf}, 40'h0);
    @(negedge clk_in);
    ready = 1'b0;
    pixel_host_model_inst.line(8, 18'h200);
    @(negedge clk_in);
    ready = 1'b1;
    check({39'h0, ovf}, 40'h1);
    $display("test stall done");
    tally_and_finish();
  end
endmodule : rgb_pixel_port_receiver_test
`default_nettype wire
